// ---- design/asrc_ctrl.sv ----
// Host-side controller driving a 32K x 8 asynchronous static RAM
// Overview of operation
// RL1 - Write enable stays high for the whole of every read cycle.
// RL2 - With the memory kept selected, only the address changes between reads; the controller raises chip select after every read instead.
// RL3 - The address is valid no later than the falling edge of chip select.
// RL4 - The memory writes only while chip select and write enable are both low.
// RL5 - A write starts with all controls active and ends when one of them rises.
// RL6 - Data setup and hold are timed from the edge that ends the write.
// RL7 - Write data is valid at least 12 ns before the write-ending edge.
// RL8 - Write data stays stable until the write-ending edge and beyond.
// RL9 - The address is valid at least 15 ns before the write-ending edge.
// RL10 - The address does not change until after the write-ending edge.
// RL11 - With output enable high in a write the memory floats its data pins.
// RL12 - The memory holds 32768 bytes on a 15-bit address and 8-bit data bus.
// RL13 - With chip select high the memory is deselected and floats its pins.
// RL14 - Chip select low, write enable high and output enable low give read data.
// RL15 - A read returns the byte last written to that location.
// RL16 - The host releases the data pins before asserting output enable.
`timescale 1ns/1ps
`default_nettype none
`include "asrc_consts.svh"
module asrc_ctrl
  import asrc_pkg::*;
#(
  parameter int AW = `ASRC_ADDR_W,
  parameter int DW = `ASRC_DATA_W
) (
  input  wire logic          CLK,
  input  wire logic          RST_B,
  // Request side
  input  wire logic          REQ_VALID,
  input  wire logic          REQ_WRITE,
  input  wire logic [AW-1:0] REQ_ADDR,
  input  wire logic [DW-1:0] REQ_WDATA,
  output logic               REQ_READY,
  output logic               RSP_VALID,
  output logic [DW-1:0]      RSP_RDATA,
  // Memory pins
  output logic [AW-1:0]      ADDR_IN,
  output logic               CS_B,
  output logic               OE_B,
  output logic               WE_B,
  input  wire logic [DW-1:0] DATA_IO_I,
  output logic [DW-1:0]      DATA_IO_O,
  output logic               DATA_IO_OE
);
  localparam int CW     = 4;
  localparam int RD_CYC = `ASRC_CYC(`ASRC_T_AA_NS) + 1;
  localparam int WS_CYC = `ASRC_CYC(`ASRC_T_AW_NS - `ASRC_T_PWE_NS);
  localparam int WE_CYC = `ASRC_CYC(`ASRC_T_PWE_NS);
  localparam int WH_CYC = `ASRC_CYC(`ASRC_T_HD_NS);
  localparam int TA_CYC = `ASRC_CYC(`ASRC_T_HZOE_NS);

  if (AW != 15 || DW != 8) begin
    $error("asrc_ctrl: memory is 32K x 8");
  end
  if (RD_CYC + 2 >= (1 << CW)) begin
    $error("asrc_ctrl: counter too narrow");
  end

  // ==========================================================
  // Input sampling of the data pins
  // ==========================================================
  logic [DW-1:0] din_s1_ff;
  logic [DW-1:0] din_s2_ff;
  logic [DW-1:0] din_s3_ff;
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      din_s1_ff <= '0;
      din_s2_ff <= '0;
      din_s3_ff <= '0;
    end else begin
      din_s1_ff <= DATA_IO_I;
      din_s2_ff <= din_s1_ff;
      din_s3_ff <= din_s2_ff;
    end
  end

  // ==========================================================
  // Phase timer
  // ==========================================================
  logic          tmr_load;
  logic [CW-1:0] tmr_count;
  logic          tmr_done;
  asrc_wait #(.W(CW)) u_wait (
    .clk   (CLK),
    .rst_b (RST_B),
    .load  (tmr_load),
    .count (tmr_count),
    .done  (tmr_done)
  );

  // ==========================================================
  // Sequencer
  // ==========================================================
  asrc_state_t   state_ff;
  asrc_state_t   nxt_state;
  logic          take;
  logic          last_wr_ff;
  assign take      = REQ_VALID && REQ_READY;
  assign REQ_READY = (state_ff == ASRC_IDLE) && tmr_done;

  always_comb begin
    nxt_state = state_ff;
    tmr_load  = 1'b0;
    tmr_count = '0;
    case (state_ff)
      ASRC_IDLE: begin
        if (take && REQ_WRITE) begin
          nxt_state = ASRC_WSET;
          tmr_load  = 1'b1;
          tmr_count = CW'(WS_CYC);
        end else if (take) begin
          nxt_state = ASRC_RD;
          tmr_load  = 1'b1;
          tmr_count = CW'(RD_CYC + 2);
        end
      end
      ASRC_RD: begin
        if (tmr_done) begin
          nxt_state = ASRC_RDEND;
          tmr_load  = 1'b1;
          tmr_count = CW'(TA_CYC);
        end
      end
      ASRC_RDEND: begin
        nxt_state = ASRC_IDLE;
      end
      ASRC_WSET: begin
        if (tmr_done) begin
          nxt_state = ASRC_WR;
          tmr_load  = 1'b1;
          tmr_count = CW'(WE_CYC);
        end
      end
      ASRC_WR: begin
        if (tmr_done) begin
          nxt_state = ASRC_WEND;
          tmr_load  = 1'b1;
          tmr_count = CW'(WH_CYC);
        end
      end
      ASRC_WEND: begin
        if (tmr_done) begin
          nxt_state = ASRC_IDLE;
        end
      end
      default: begin
        nxt_state = ASRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state_ff <= ASRC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Address and data registers held through the whole cycle
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ADDR_IN    <= '0;
      DATA_IO_O  <= '0;
      last_wr_ff <= 1'b0;
    end else if (take) begin
      ADDR_IN    <= REQ_ADDR;  // [RL3] [RL9] [RL10]
      last_wr_ff <= REQ_WRITE;
      if (REQ_WRITE) begin
        DATA_IO_O <= REQ_WDATA;  // [RL7] [RL8]
      end
    end
  end

  // ==========================================================
  // Memory control pins
  // ==========================================================
  // Chip select falls with the address, never before it
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      CS_B <= 1'b1;
    end else begin
      CS_B <= !(nxt_state == ASRC_RD || nxt_state == ASRC_WSET
                || nxt_state == ASRC_WR || nxt_state == ASRC_WEND);  // [RL2] [RL3] [RL13]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      WE_B <= 1'b1;
    end else begin
      WE_B <= !(nxt_state == ASRC_WR);  // [RL1] [RL4] [RL5] [RL6]
    end
  end

  // Output enable only after the host has let go of the bus
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      OE_B <= 1'b1;
    end else begin
      OE_B <= !(state_ff == ASRC_RD && nxt_state == ASRC_RD);  // [RL14] [RL16]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      DATA_IO_OE <= 1'b0;
    end else begin
      DATA_IO_OE <= (nxt_state == ASRC_WSET || nxt_state == ASRC_WR
                     || nxt_state == ASRC_WEND);  // [RL11] [RL16]
    end
  end

  // ==========================================================
  // Read response
  // ==========================================================
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      RSP_VALID <= 1'b0;
      RSP_RDATA <= '0;
    end else begin
      RSP_VALID <= 1'b0;
      if (state_ff == ASRC_RD && tmr_done && !last_wr_ff) begin
        RSP_VALID <= 1'b1;
        RSP_RDATA <= din_s3_ff;  // [RL12] [RL15]
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/asrc_wait.sv ----
// Down counter that times one phase of a memory cycle
`timescale 1ns/1ps
`default_nettype none
module asrc_wait #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_ff;
  if (W < 1) begin
    $error("asrc_wait: W must be positive");
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= count;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end
  // Done from the count alone, so ready never loops back through load
  assign done = (cnt_ff == '0);
endmodule
`default_nettype wire

// ---- dv/asrc_ctrl_properties.sv ----
// Pin timing checks for the SRAM controller
`timescale 1ns/1ps
`default_nettype none
module asrc_ctrl_chk #(
  parameter int AW = 15,
  parameter int DW = 8
) (
  input wire logic          CLK,
  input wire logic          RST_B,
  input wire logic          REQ_VALID,
  input wire logic          REQ_WRITE,
  input wire logic          REQ_READY,
  input wire logic          RSP_VALID,
  input wire logic [AW-1:0] ADDR_IN,
  input wire logic          CS_B,
  input wire logic          OE_B,
  input wire logic          WE_B,
  input wire logic [DW-1:0] DATA_IO_O,
  input wire logic          DATA_IO_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic take;
  assign take = REQ_VALID && REQ_READY;
  a_read_we_high: assert property (!CS_B && !OE_B |-> WE_B)
    else $error("write enable low in read");
  a_addr_held_cs: assert property (!CS_B && !$past(CS_B) |-> $stable(ADDR_IN))
    else $error("address moved while selected");
  a_we_needs_cs: assert property (!WE_B |-> !CS_B && !$past(CS_B))
    else $error("write enable without select");
  a_data_setup: assert property ($rose(WE_B) |-> $past(DATA_IO_OE, 2) && $stable(DATA_IO_O))
    else $error("write data setup short");
  a_data_hold: assert property ($rose(WE_B) |-> DATA_IO_OE && !CS_B)
    else $error("write data not held");
  a_addr_setup: assert property (!WE_B |-> $stable(ADDR_IN) && !$past(CS_B))
    else $error("address setup short");
  a_addr_hold: assert property ($rose(WE_B) |-> $stable(ADDR_IN))
    else $error("address not held");
  a_bus_released: assert property (!OE_B |-> !DATA_IO_OE && !$past(DATA_IO_OE))
    else $error("host drives during read");
  a_write_start: assert property (take && REQ_WRITE |-> ##[1:3] !WE_B)
    else $error("write pulse missing");
  a_read_answer: assert property (take && !REQ_WRITE |-> ##[5:9] RSP_VALID)
    else $error("read answer missing");
endmodule
bind asrc_ctrl asrc_ctrl_chk #(.AW(AW), .DW(DW)) u_chk (.CLK(CLK), .RST_B(RST_B),
  .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
  .ADDR_IN(ADDR_IN), .CS_B(CS_B), .OE_B(OE_B), .WE_B(WE_B), .DATA_IO_O(DATA_IO_O),
  .DATA_IO_OE(DATA_IO_OE));
`default_nettype wire

// ---- dv/asrc_sram_model.sv ----
// Behavioural 32K x 8 static RAM on the controller pins
`timescale 1ns/1ps
`default_nettype none
module asrc_sram_model #(
  parameter int AW = 15,
  parameter int DW = 8
) (
  input  wire logic [AW-1:0] addr,
  input  wire logic          cs_b,
  input  wire logic          oe_b,
  input  wire logic          we_b,
  input  wire logic [DW-1:0] host_do,
  input  wire logic          host_oe,
  output logic      [DW-1:0] bus
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic          rd_on;
  assign rd_on = !cs_b && we_b && !oe_b;
  // Released bus shows the inverse byte, never a stale one
  assign bus = host_oe ? host_do : (rd_on ? mem[addr] : ~mem[addr]);
  always @(posedge we_b) if (!cs_b) mem[addr] = bus;
  always @(posedge cs_b) if (!we_b) mem[addr] = bus;
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the SRAM controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 0, rst_b = 0, req_valid = 0, req_write = 0;
  logic [14:0] req_addr = 15'h0, addr_in;
  logic [7:0]  req_wdata = 8'h0, rsp_rdata, data_o, bus;
  logic        req_ready, rsp_valid, cs_b, oe_b, we_b, data_oe;
  int          err_count = 0, tests_run = 0;
  always #25 clk = ~clk;
  asrc_ctrl u_dut (.CLK(clk), .RST_B(rst_b), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
    .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
    .RSP_RDATA(rsp_rdata), .ADDR_IN(addr_in), .CS_B(cs_b), .OE_B(oe_b), .WE_B(we_b),
    .DATA_IO_I(bus), .DATA_IO_O(data_o), .DATA_IO_OE(data_oe));
  asrc_sram_model u_mem (.addr(addr_in), .cs_b(cs_b), .oe_b(oe_b), .we_b(we_b),
    .host_do(data_o), .host_oe(data_oe), .bus(bus));
  task wrap_up;
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(string what, logic [14:0] exp, logic [14:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Wait at falling edges: ready (0), answer (1), write pulse (2); bounded
  task automatic wait_hi(input int sel);
    int   n;
    logic hit;
    n   = 0;
    hit = 1'b0;
    while (!hit) begin
      @(negedge clk);
      case (sel)
        0:       hit = (req_ready === 1'b1);
        1:       hit = (rsp_valid === 1'b1);
        default: hit = (we_b === 1'b0);
      endcase
      n++;
      if (!hit && n > 40) begin
        err_count++;
        wrap_up();
      end
    end
  endtask
  task req(logic w, logic [14:0] a, logic [7:0] d);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= d;
    wait_hi(0);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  // Write, check the pins during the pulse, wait until the bus is let go
  task wr(logic [14:0] a, logic [7:0] d);
    req(1'b1, a, d);
    wait_hi(2);
    chk("write addr", a, addr_in);
    chk("write data", {7'h0, d}, {7'h0, data_o});
    chk("write select", 15'h1, {13'h0, cs_b, data_oe});
    wait_hi(0);
    chk("write release", 15'hE, {11'h0, cs_b, oe_b, we_b, data_oe});
  endtask
  task rd(logic [14:0] a, logic [7:0] exp);
    req(1'b0, a, 8'h00);
    wait_hi(1);
    chk("read byte", {7'h0, exp}, {7'h0, rsp_rdata});
  endtask
  task sc_idle;
    @(negedge clk);
    chk("idle pins", 15'h7, {12'h0, cs_b, oe_b, we_b});
    chk("idle drive", 15'h0, {14'h0, data_oe});
  endtask
  task sc_edges;
    wr(15'h0000, 8'hA5);
    wr(15'h7FFF, 8'h5A);
    chk("stored byte", 15'h005A, {7'h0, u_mem.mem[15'h7FFF]});
    rd(15'h0000, 8'hA5);
    rd(15'h7FFF, 8'h5A);
  endtask
  task sc_overwrite;
    wr(15'h1234, 8'h3C);
    wr(15'h1234, 8'hC3);
    rd(15'h1234, 8'hC3);
    rd(15'h1234, 8'hC3);
    chk("kept byte", 15'h00C3, {7'h0, u_mem.mem[15'h1234]});
  endtask
  task sc_addr_bits;
    for (int i = 0; i < 15; i++) wr(15'h1 << i, 8'(i + 8'h10));
    for (int i = 0; i < 15; i++) rd(15'h1 << i, 8'(i + 8'h10));
  endtask
  // Reset in the middle of a read, then a clean read
  task sc_reset;
    req(1'b0, 15'h0001, 8'h00);
    repeat (2) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("reset pins", 15'h7, {12'h0, cs_b, oe_b, we_b});
    chk("reset answer", 15'h0, {14'h0, rsp_valid});
    chk("reset ready", 15'h1, {14'h0, req_ready});
    rd(15'h0001, 8'h10);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    sc_idle();
    sc_edges();
    sc_overwrite();
    sc_addr_bits();
    sc_reset();
    sc_idle();
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- include/asrc_consts.svh ----
// Timing counts and widths for the asynchronous SRAM controller
`ifndef ASRC_CONSTS_SVH
`define ASRC_CONSTS_SVH
`define ASRC_CLK_PERIOD_NS     50
`define ASRC_ADDR_W            15
`define ASRC_DATA_W            8
// Fast grade figures, ns
`define ASRC_T_RC_NS           25
`define ASRC_T_AA_NS           25
`define ASRC_T_WC_NS           25
`define ASRC_T_PWE_NS          15
`define ASRC_T_AW_NS           15
`define ASRC_T_SD_NS           12
`define ASRC_T_HZOE_NS         12
`define ASRC_T_HA_NS           0
`define ASRC_T_HD_NS           0
`define ASRC_CYC_MIN(ns)       (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_CYC(ns)           ((`ASRC_CYC_MIN(ns) < 1) ? 1 : `ASRC_CYC_MIN(ns))
`endif

// ---- include/asrc_pkg.sv ----
// Types for the asynchronous SRAM controller
package asrc_pkg;
  typedef enum logic [2:0] {
    ASRC_IDLE  = 3'h0,
    ASRC_RD    = 3'h1,
    ASRC_RDEND = 3'h3,
    ASRC_WSET  = 3'h2,
    ASRC_WR    = 3'h6,
    ASRC_WEND  = 3'h7
  } asrc_state_t;
endpackage
